// file: meter_handler_pkg.sv
// Shared constants and carriers of the handshake block
package meter_handler_pkg;

  // Widths
  localparam int VAL_W    = 16;
  localparam int NBINS    = 9;
  localparam int NOUTBINS = NBINS + 2;
  localparam int ADDR_W   = 8;
  localparam int PCT_W    = 7;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_START  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FAULT  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LOWC   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_SEC    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_BINLO  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_BINHI  = 8'h80;
  localparam logic [ADDR_W-1:0] BIN_SPAN   = 8'h24;

  // Control register fields
  localparam int CTRL_EXT     = 0;
  localparam int CTRL_FREQ_LO = 1;
  localparam int CTRL_AUX     = 3;
  localparam int CTRL_BEN_LO  = 4;
  localparam int CTRL_W       = CTRL_BEN_LO + NBINS;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h1ff0;

  // Other field positions
  localparam int LOWC_FS_LO = 8;
  localparam int SEC_HI_LO  = 16;
  localparam int STAT_ST_LO = 8;
  localparam logic [PCT_W-1:0] LOWC_PCT_RST = 7'h05;
  localparam logic [PCT_W-1:0] PCT_FULL     = 7'h64;
  localparam logic [VAL_W-1:0] VAL_MAX      = 16'hffff;
  localparam logic [VAL_W-1:0] VAL_ZERO     = 16'h0000;

  // Test frequency codes
  typedef enum logic [1:0] {
    FREQ_120HZ,
    FREQ_1KHZ,
    FREQ_1MHZ
  } freq_t;

  // Outer bins beyond the nine sorting bins
  localparam int BIN_OUT = NBINS;
  localparam int BIN_AUX = NBINS + 1;

  // Analog section report, one-cycle done strobe
  typedef struct packed {
    logic             done;
    logic             overload;
    logic             no_contact;
    logic [VAL_W-1:0] cap;
  } analog_result_t;

  // Computation section report, one-cycle done strobe
  typedef struct packed {
    logic             done;
    logic [VAL_W-1:0] primary;
    logic [VAL_W-1:0] secondary;
  } calc_result_t;

  // Judgment outputs toward the handler, all active low
  typedef struct packed {
    logic [NOUTBINS-1:0] bin_result_n;
    logic                primary_high_reject_n;
    logic                primary_low_reject_n;
    logic                secondary_reject_n;
    logic                overload_n;
    logic                small_or_open_reject_n;
  } judgment_t;

  localparam judgment_t JUDGE_IDLE = '1;

endpackage

// file: handler_input_stage.sv
// Trigger edge detection and front-panel lockout gating
`timescale 1ns/1ps
`default_nettype none
module handler_input_stage #(
  parameter int KEY_W = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Handler inputs
  input  wire logic             external_start_pulse,
  input  wire logic             panel_lock_n,
  // Front panel
  input  wire logic [KEY_W-1:0] key_press,
  output logic      [KEY_W-1:0] key_accept,
  // Decoded trigger
  output logic                  trig_rise
);

  logic trig_ff;

  // Previous trigger level for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= external_start_pulse;
    end
  end

  assign trig_rise = external_start_pulse & ~trig_ff;

  // Keys vanish while the handler holds the lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_accept <= '0;
    end else begin
      key_accept <= panel_lock_n ? key_press : '0;
    end
  end

endmodule // handler_input_stage
`default_nettype wire

// file: meter_handler_handshake.sv
// Handler handshake and judgment output logic of the capacitance meter
//
// Contract
// - Primary above every bin drives primary-high reject low.
// - Primary below every bin drives primary-low reject low.
// - Secondary reject low when secondary lies outside its limits.
// - Trigger-accept low once a new trigger can be taken.
// - Small-or-open reject low at or below a percentage of range.
// - No-contact flags small-or-open only at 120 Hz and 1 kHz.
// - Overload low when the analog section cannot finish.
// - Front-panel keys ignored while panel lockout is low.
// - Fault low on self-test error, power loss or circuit malfunction.
// - Power-loss fault lasts only while power stays down.
// - Analog-done low as soon as the analog phase ends.
// - Cycle-done low when the sequence ends and judgment is valid.
// - Judgment outputs are invalid during computation after analog phase.
// - In external mode, a rising trigger edge starts a measurement.
// - Exactly one bin output asserted; none on overload.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module meter_handler_handshake #(
  parameter int KEY_W = 8
) (
  // Clock and reset
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  // APB slave
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [meter_handler_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                             pwdata,
  output logic      [31:0]                             prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  // Handler inputs
  input  wire logic                                    external_start_pulse,
  input  wire logic                                    panel_lock_n,
  // Handler outputs
  output logic                                         trigger_accept_n,
  output logic                                         analog_done_n,
  output logic                                         cycle_done_n,
  output logic                                         fault_n,
  output meter_handler_pkg::judgment_t                 judgment,
  // Front panel
  input  wire logic [KEY_W-1:0]                        key_press,
  output logic      [KEY_W-1:0]                        key_accept,
  // Measurement sections
  output logic                                         meas_start,
  input  wire meter_handler_pkg::analog_result_t       analog_in,
  input  wire meter_handler_pkg::calc_result_t         calc_in,
  // Supervision
  input  wire logic                                    power_down,
  input  wire logic                                    selftest_err,
  input  wire logic                                    circuit_fault
);

  localparam int VW = meter_handler_pkg::VAL_W;
  localparam int NB = meter_handler_pkg::NBINS;

  typedef enum logic [2:0] {
    ST_READY,
    ST_ANALOG,
    ST_COMPUTE,
    ST_JUDGE
  } state_t;

  state_t                                   state_ff;
  state_t                                   nxt_state;
  logic [meter_handler_pkg::CTRL_W-1:0]     ctrl_ff;
  logic [meter_handler_pkg::PCT_W-1:0]      lowc_pct_ff;
  logic [VW-1:0]                            range_fs_ff;
  logic [VW-1:0]                            sec_lo_ff;
  logic [VW-1:0]                            sec_hi_ff;
  logic [VW-1:0]                            bin_lo_ff [NB];
  logic [VW-1:0]                            bin_hi_ff [NB];
  logic                                     selftest_ff;
  logic                                     circuit_ff;
  logic                                     power_ff;
  logic                                     overload_n_ff;
  logic                                     small_open_ff;
  logic [VW-1:0]                            prim_ff;
  logic [VW-1:0]                            sec_ff;
  logic                                     sw_start_ff;
  logic [31:0]                              prdata_ff;
  logic                                     trig_rise;
  logic                                     start_now;
  logic                                     wr_en;
  logic                                     setup;
  logic                                     hit;
  logic [31:0]                              rdata;
  logic [NB-1:0]                            in_bin;
  logic [NB-1:0]                            above;
  logic [NB-1:0]                            below;
  logic                                     ext_mode;
  logic                                     aux_en;
  logic [NB-1:0]                            bin_en;
  logic [1:0]                               freq;
  logic [3:0]                               bin_idx;
  logic                                     lo_hit;
  logic                                     hi_hit;
  logic [VW+meter_handler_pkg::PCT_W-1:0]   cap_scaled;
  logic [VW+meter_handler_pkg::PCT_W-1:0]   fs_scaled;
  meter_handler_pkg::judgment_t             nxt_judgment;

  assign ext_mode = ctrl_ff[meter_handler_pkg::CTRL_EXT];
  assign aux_en   = ctrl_ff[meter_handler_pkg::CTRL_AUX];
  assign freq     = ctrl_ff[meter_handler_pkg::CTRL_FREQ_LO +: 2];
  assign bin_en   = ctrl_ff[meter_handler_pkg::CTRL_BEN_LO +: NB];

  handler_input_stage #(
    .KEY_W (KEY_W)
  ) u_inputs (
    .pclk,
    .presetn,
    .external_start_pulse,
    .panel_lock_n,
    .key_press,
    .key_accept,
    .trig_rise
  );

  // APB decode; no wait states, read data staged at setup
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & hit;
  assign bin_idx = paddr[5:2];
  assign lo_hit  = (paddr >= meter_handler_pkg::OFS_BINLO) &&
                   (paddr < meter_handler_pkg::OFS_BINLO + meter_handler_pkg::BIN_SPAN);
  assign hi_hit  = (paddr >= meter_handler_pkg::OFS_BINHI) &&
                   (paddr < meter_handler_pkg::OFS_BINHI + meter_handler_pkg::BIN_SPAN);

  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    if (lo_hit) begin
      rdata[VW-1:0] = bin_lo_ff[bin_idx];
    end else if (hi_hit) begin
      rdata[VW-1:0] = bin_hi_ff[bin_idx];
    end else begin
      unique case (paddr)
        meter_handler_pkg::OFS_CTRL: begin
          rdata[meter_handler_pkg::CTRL_W-1:0] = ctrl_ff;
        end
        meter_handler_pkg::OFS_START: begin
          rdata = '0;
        end
        meter_handler_pkg::OFS_STATUS: begin
          rdata[0] = trigger_accept_n;
          rdata[1] = analog_done_n;
          rdata[2] = cycle_done_n;
          rdata[3] = fault_n;
          rdata[4] = panel_lock_n;
          rdata[meter_handler_pkg::STAT_ST_LO +: 3] = state_ff;
        end
        meter_handler_pkg::OFS_FAULT: begin
          rdata[0] = selftest_ff;
          rdata[1] = circuit_ff;
          rdata[2] = power_ff;
        end
        meter_handler_pkg::OFS_LOWC: begin
          rdata[meter_handler_pkg::PCT_W-1:0] = lowc_pct_ff;
          rdata[meter_handler_pkg::LOWC_FS_LO +: VW] = range_fs_ff;
        end
        meter_handler_pkg::OFS_SEC: begin
          rdata[VW-1:0] = sec_lo_ff;
          rdata[meter_handler_pkg::SEC_HI_LO +: VW] = sec_hi_ff;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (setup) begin
      prdata_ff <= rdata;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= meter_handler_pkg::CTRL_RST;
      lowc_pct_ff <= meter_handler_pkg::LOWC_PCT_RST;
      range_fs_ff <= meter_handler_pkg::VAL_MAX;
      sec_lo_ff   <= meter_handler_pkg::VAL_ZERO;
      sec_hi_ff   <= meter_handler_pkg::VAL_MAX;
    end else if (wr_en) begin
      if (paddr == meter_handler_pkg::OFS_CTRL) begin
        ctrl_ff <= pwdata[meter_handler_pkg::CTRL_W-1:0];
      end
      if (paddr == meter_handler_pkg::OFS_LOWC) begin
        lowc_pct_ff <= pwdata[meter_handler_pkg::PCT_W-1:0];
        range_fs_ff <= pwdata[meter_handler_pkg::LOWC_FS_LO +: VW];
      end
      if (paddr == meter_handler_pkg::OFS_SEC) begin
        sec_lo_ff <= pwdata[VW-1:0];
        sec_hi_ff <= pwdata[meter_handler_pkg::SEC_HI_LO +: VW];
      end
    end
  end

  // Bin limits and per-bin comparison
  for (genvar i = 0; i < NB; i++) begin : g_bin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bin_lo_ff[i] <= meter_handler_pkg::VAL_ZERO;
        bin_hi_ff[i] <= meter_handler_pkg::VAL_MAX;
      end else if (wr_en && bin_idx == 4'(i)) begin
        if (lo_hit) begin
          bin_lo_ff[i] <= pwdata[VW-1:0];
        end
        if (hi_hit) begin
          bin_hi_ff[i] <= pwdata[VW-1:0];
        end
      end
    end
    // Disabled bins never match and never bound the range
    assign above[i]  = ~bin_en[i] | (prim_ff > bin_hi_ff[i]);
    assign below[i]  = ~bin_en[i] | (prim_ff < bin_lo_ff[i]);
    assign in_bin[i] = bin_en[i] & ~above[i] & ~below[i];
  end

  // Software start, usable only in internal trigger mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_start_ff <= 1'b0;
    end else begin
      sw_start_ff <= wr_en && paddr == meter_handler_pkg::OFS_START && pwdata[0];
    end
  end

  // Triggers outside the ready state are dropped
  assign start_now = (state_ff == ST_READY) &&
                     (ext_mode ? trig_rise : sw_start_ff);

  // Measurement sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_READY: begin
        if (start_now) begin
          nxt_state = ST_ANALOG;
        end
      end
      ST_ANALOG: begin
        if (analog_in.done) begin
          nxt_state = analog_in.overload ? ST_JUDGE : ST_COMPUTE;
        end
      end
      ST_COMPUTE: begin
        if (calc_in.done) begin
          nxt_state = ST_JUDGE;
        end
      end
      ST_JUDGE: begin
        nxt_state = ST_READY;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_READY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_start <= 1'b0;
    end else begin
      meas_start <= start_now;
    end
  end

  // Handshake outputs; cycle-done lands with judgment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_accept_n <= 1'b0;
      analog_done_n    <= 1'b1;
      cycle_done_n     <= 1'b1;
    end else if (start_now) begin
      trigger_accept_n <= 1'b1;
      analog_done_n    <= 1'b1;
      cycle_done_n     <= 1'b1;
    end else begin
      if (state_ff == ST_ANALOG && analog_in.done) begin
        analog_done_n <= 1'b0;
      end
      if (state_ff == ST_JUDGE) begin
        cycle_done_n     <= 1'b0;
        trigger_accept_n <= 1'b0;
      end
    end
  end

  // Analog and computed results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overload_n_ff       <= 1'b0;
      small_open_ff <= 1'b0;
      prim_ff       <= meter_handler_pkg::VAL_ZERO;
      sec_ff        <= meter_handler_pkg::VAL_ZERO;
    end else begin
      if (state_ff == ST_ANALOG && analog_in.done) begin
        overload_n_ff       <= analog_in.overload;
        small_open_ff <= (cap_scaled <= fs_scaled) ||
                         (analog_in.no_contact &&
                          (freq == meter_handler_pkg::FREQ_120HZ ||
                           freq == meter_handler_pkg::FREQ_1KHZ));
      end
      if (state_ff == ST_COMPUTE && calc_in.done) begin
        prim_ff <= calc_in.primary;
        sec_ff  <= calc_in.secondary;
      end
    end
  end

  // Boundary as percent of range, compared without a divider
  assign cap_scaled = analog_in.cap * meter_handler_pkg::PCT_FULL;
  assign fs_scaled  = range_fs_ff * lowc_pct_ff;

  // Sorting judgment
  always_comb begin
    nxt_judgment = meter_handler_pkg::JUDGE_IDLE;
    nxt_judgment.small_or_open_reject_n = ~small_open_ff;
    if (overload_n_ff) begin
      nxt_judgment.overload_n = 1'b0;
    end else begin
      if (sec_ff < sec_lo_ff || sec_ff > sec_hi_ff) begin
        nxt_judgment.secondary_reject_n = 1'b0;
      end
      if (&above) begin
        nxt_judgment.primary_high_reject_n       = 1'b0;
        nxt_judgment.bin_result_n[meter_handler_pkg::BIN_OUT] = 1'b0;
      end else if (&below) begin
        nxt_judgment.primary_low_reject_n        = 1'b0;
        nxt_judgment.bin_result_n[meter_handler_pkg::BIN_OUT] = 1'b0;
      end else if (~|in_bin) begin
        nxt_judgment.primary_high_reject_n       = 1'b0;
        nxt_judgment.bin_result_n[meter_handler_pkg::BIN_OUT] = 1'b0;
      end else if (!nxt_judgment.secondary_reject_n) begin
        nxt_judgment.bin_result_n[aux_en ? meter_handler_pkg::BIN_AUX
                                         : meter_handler_pkg::BIN_OUT] = 1'b0;
      end else begin
        for (int b = NB - 1; b >= 0; b--) begin
          if (in_bin[b]) begin
            nxt_judgment.bin_result_n = '1;
            nxt_judgment.bin_result_n[b] = 1'b0;
          end
        end
      end
    end
  end

  // Inactive during a cycle, updated only at judgment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      judgment <= meter_handler_pkg::JUDGE_IDLE;
    end else if (start_now) begin
      judgment <= meter_handler_pkg::JUDGE_IDLE;
    end else if (state_ff == ST_JUDGE) begin
      judgment <= nxt_judgment;
    end
  end

  // Fault sources; set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selftest_ff <= 1'b0;
      circuit_ff  <= 1'b0;
      power_ff    <= 1'b0;
    end else begin
      power_ff <= power_down;
      if (selftest_err) begin
        selftest_ff <= 1'b1;
      end else if (wr_en && paddr == meter_handler_pkg::OFS_FAULT && pwdata[0]) begin
        selftest_ff <= 1'b0;
      end
      if (circuit_fault) begin
        circuit_ff <= 1'b1;
      end else if (wr_en && paddr == meter_handler_pkg::OFS_FAULT && pwdata[1]) begin
        circuit_ff <= 1'b0;
      end
    end
  end

  assign fault_n = ~(selftest_ff | circuit_ff | power_ff);

endmodule // meter_handler_handshake
`default_nettype wire

// file: handshake_monitor.sv
// Checker for the handler handshake outputs
`timescale 1ns/1ps
`default_nettype none
module handshake_monitor #(
  parameter int KEY_W = 8
) (
  // Clock and reset
  input wire logic                              pclk,
  input wire logic                              presetn,
  // Handler side
  input wire logic                              panel_lock_n,
  input wire logic                              trigger_accept_n,
  input wire logic                              analog_done_n,
  input wire logic                              cycle_done_n,
  input wire logic                              fault_n,
  input wire meter_handler_pkg::judgment_t      judgment,
  input wire logic [KEY_W-1:0]                  key_accept,
  // Measurement and supervision
  input wire logic                              meas_start,
  input wire meter_handler_pkg::analog_result_t analog_in,
  input wire logic                              power_down
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic busy;
  // Mid-cycle, before analog end
  assign busy = trigger_accept_n && analog_done_n && cycle_done_n;

  a_start_release: assert property (
    meas_start |-> busy && judgment == meter_handler_pkg::JUDGE_IDLE) else $error("start not clean");
  a_accept_stands: assert property (
    trigger_accept_n && cycle_done_n |=> trigger_accept_n || !cycle_done_n) else $error("accept early");
  a_done_frees: assert property (
    $fell(cycle_done_n) |-> !trigger_accept_n && !analog_done_n) else $error("done order");
  a_hidden_judge: assert property (
    trigger_accept_n && cycle_done_n |-> judgment == meter_handler_pkg::JUDGE_IDLE) else $error("judge shown");
  a_analog_end: assert property (
    analog_in.done && busy && !meas_start |=> !analog_done_n) else $error("analog done late");
  a_overload_path: assert property (
    analog_in.done && analog_in.overload && busy && !meas_start |=> ##[1:3]
    (!cycle_done_n && !judgment.overload_n && &judgment.bin_result_n)) else $error("overload path");
  a_bin_onehot: assert property (
    $fell(cycle_done_n) && judgment.overload_n && judgment.small_or_open_reject_n
    |-> $onehot(~judgment.bin_result_n)) else $error("bin not onehot");
  a_power_fault: assert property (
    power_down |=> !fault_n) else $error("power fault missing");
  a_key_locked: assert property (
    !panel_lock_n ##1 !panel_lock_n |-> key_accept == '0) else $error("key passed");

  c_cycle: cover property ($fell(cycle_done_n));
  c_overload: cover property (!judgment.overload_n);
  c_fault: cover property (!fault_n);
endmodule // handshake_monitor

bind meter_handler_handshake handshake_monitor #(.KEY_W(KEY_W)) i_handshake_monitor (
  .pclk, .presetn, .panel_lock_n, .trigger_accept_n, .analog_done_n, .cycle_done_n,
  .fault_n, .judgment, .key_accept, .meas_start, .analog_in, .power_down);
`default_nettype wire

// file: handler_model.sv
// Handler model: triggers when allowed, takes results at cycle end
`timescale 1ns/1ps
`default_nettype none
module handler_model #(
  parameter int PULSE_CYC = 100
) (
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // Bench request
  input  wire logic                         go,
  // Meter side
  input  wire logic                         trigger_accept_n,
  input  wire logic                         cycle_done_n,
  input  wire meter_handler_pkg::judgment_t judgment,
  output logic                              external_start_pulse,
  output meter_handler_pkg::judgment_t      seen
);
  int   hold_ff;
  logic done_ff;
  // Pulse of 1 us at 100 MHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_start_pulse <= 1'b0;
      hold_ff <= 0;
    end else if (hold_ff != 0) begin
      hold_ff <= hold_ff - 1;
      external_start_pulse <= (hold_ff != 1);
    end else if (go && !trigger_accept_n) begin
      external_start_pulse <= 1'b1;
      hold_ff <= PULSE_CYC;
    end
  end
  // Results only read once the cycle ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b1;
      seen <= meter_handler_pkg::JUDGE_IDLE;
    end else begin
      done_ff <= cycle_done_n;
      if (done_ff && !cycle_done_n) seen <= judgment;
    end
  end
endmodule // handler_model
`default_nettype wire

// file: meter_handler_handshake_bench.sv
// Self-checking bench for the handler handshake block
`timescale 1ns/1ps
`default_nettype none
module meter_handler_handshake_bench;
  typedef struct {
    logic [15:0] cap;
    logic        ovl;
    logic [15:0] pri;
    logic [15:0] sec;
    logic [15:0] exp;
  } row_t;
  logic        pclk = 1'b0, presetn = 1'b0, go = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]  paddr = 8'h00, key_press = 8'h00, key_accept;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        panel_lock_n = 1'b1, power_down = 1'b0, selftest_err = 1'b0;
  logic        external_start_pulse, trigger_accept_n, analog_done_n;
  logic        cycle_done_n, fault_n, meas_start, circuit_fault = 1'b0;
  meter_handler_pkg::judgment_t      judgment, seen;
  meter_handler_pkg::analog_result_t analog_in = '0;
  meter_handler_pkg::calc_result_t   calc_in = '0;
  int n_mismatch = 0, n_compared = 0;
  // Bin 0 spans 100h..200h, secondary 10h..20h
  row_t rows [6] = '{
    '{16'h1000, 1'b0, 16'h0150, 16'h0018, 16'hffdf},
    '{16'h1000, 1'b0, 16'h0300, 16'h0018, 16'hbfef},
    '{16'h1000, 1'b0, 16'h0050, 16'h0018, 16'hbff7},
    '{16'h1000, 1'b0, 16'h0150, 16'h0030, 16'hbffb},
    '{16'h1000, 1'b1, 16'h0150, 16'h0018, 16'hfffd},
    '{16'h0000, 1'b0, 16'h0150, 16'h0018, 16'hffde}};

  meter_handler_handshake i_meter_handler_handshake (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_start_pulse, .panel_lock_n, .trigger_accept_n, .analog_done_n, .cycle_done_n,
    .fault_n, .judgment, .key_press, .key_accept, .meas_start, .analog_in, .calc_in,
    .power_down, .selftest_err, .circuit_fault);
  handler_model i_handler_model (
    .pclk, .presetn, .go, .trigger_accept_n, .cycle_done_n, .judgment,
    .external_start_pulse, .seen);

  always #5 pclk = ~pclk;

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  // Bounded wait: 0 for start pulse, 1 for cycle end
  task automatic await(input int sel);
    int k = 0;
    while ((sel == 0 ? meas_start !== 1'b1 : cycle_done_n !== 1'b0) && k < 400) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 400) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic meas(input logic [15:0] cap, input logic ovl, nc,
                      input logic [15:0] pri, sec);
    go <= 1'b1;
    await(0);
    go <= 1'b0;
    repeat (3) @(posedge pclk);
    analog_in <= '{1'b1, ovl, nc, cap};
    @(posedge pclk);
    analog_in.done <= 1'b0;
    @(posedge pclk);
    chk("analog_done_n", 32'h0, 32'(analog_done_n));
    if (!ovl) begin
      calc_in <= '{1'b1, pri, sec};
      @(posedge pclk);
      calc_in.done <= 1'b0;
    end
    await(1);
    @(posedge pclk);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, meter_handler_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h00001ff0, rd);
    apb(1'b0, meter_handler_pkg::OFS_LOWC, 32'h0);
    chk("lowc reset", 32'h00ffff05, rd);
    apb(1'b0, 8'hc8, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b1, meter_handler_pkg::OFS_CTRL, 32'h11);
    apb(1'b1, meter_handler_pkg::OFS_BINLO, 32'h100);
    apb(1'b1, meter_handler_pkg::OFS_BINHI, 32'h200);
    apb(1'b1, meter_handler_pkg::OFS_SEC, 32'h00200010);
    apb(1'b0, meter_handler_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'h11, rd);
    $display("test registers done");
    foreach (rows[i]) begin
      meas(rows[i].cap, rows[i].ovl, 1'b0, rows[i].pri, rows[i].sec);
      chk("judgment", {16'h0, rows[i].exp}, {16'h0, seen});
    end
    $display("test sorting done");
    meas(16'h1000, 1'b0, 1'b1, 16'h150, 16'h18);
    chk("open 120hz", 32'h0, 32'(seen.small_or_open_reject_n));
    apb(1'b1, meter_handler_pkg::OFS_CTRL, 32'h15);
    meas(16'h1000, 1'b0, 1'b1, 16'h150, 16'h18);
    chk("open 1mhz", 32'h1, 32'(seen.small_or_open_reject_n));
    meas(16'h0000, 1'b0, 1'b0, 16'h150, 16'h18);
    chk("lowc 1mhz", 32'h0, 32'(seen.small_or_open_reject_n));
    $display("test contact done");
    selftest_err <= 1'b1;
    circuit_fault <= 1'b1;
    @(posedge pclk);
    selftest_err <= 1'b0;
    circuit_fault <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("fault selftest", 32'h0, 32'(fault_n));
    apb(1'b1, meter_handler_pkg::OFS_FAULT, 32'h1);
    chk("fault circuit", 32'h0, 32'(fault_n));
    apb(1'b1, meter_handler_pkg::OFS_FAULT, 32'h2);
    chk("fault cleared", 32'h1, 32'(fault_n));
    power_down <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("fault power", 32'h0, 32'(fault_n));
    power_down <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("fault power gone", 32'h1, 32'(fault_n));
    $display("test fault done");
    panel_lock_n <= 1'b0;
    key_press <= 8'h5a;
    repeat (2) @(posedge pclk);
    chk("keys locked", 32'h0, 32'(key_accept));
    panel_lock_n <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("keys free", 32'h5a, 32'(key_accept));
    $display("test keys done");
    wrap_up();
  end
endmodule // meter_handler_handshake_bench
`default_nettype wire
